// ===== verilog/dpe_pkg.sv
// Shared constants and types for the data-space paging and nonvolatile block
package dpe_pkg;
    // Data-space register addresses
    localparam logic [7:0] ADDR_WIN_PAGE = 8'hC9;
    localparam logic [7:0] ADDR_BANK_SEL = 8'hE8;
    localparam logic [7:0] ADDR_NVM_CTL = 8'hEA;
    // Data-space regions
    localparam logic [7:0] WIN_FIRST = 8'h40;
    localparam logic [7:0] WIN_LAST = 8'h7F;
    localparam logic [7:0] BANK_LAST = 8'h3F;
    // Bank-select encodings and bit positions
    localparam logic [7:0] BANK_NONE = 8'h00;
    localparam logic [7:0] BANK_NVM0 = 8'h01;
    localparam logic [7:0] BANK_NVM1 = 8'h02;
    localparam logic [7:0] BANK_RAM2 = 8'h10;
    localparam int SEL_NVM0 = 0;
    localparam int SEL_NVM1 = 1;
    localparam int SEL_RAM2 = 4;
    // Control register bit positions
    localparam int CTL_WE = 0;
    localparam int CTL_BUSY = 1;
    localparam int CTL_LOAD = 2;
    localparam int CTL_START = 3;
    localparam int CTL_OFF = 6;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Sizes
    localparam int NVM_BYTES = 128;
    localparam int RAM2_BYTES = 64;
    localparam int ROW_BYTES = 8;
    // Value returned by a meaningless nonvolatile read
    localparam logic [7:0] READ_EMPTY = 8'hFF;
    // Programming time; arbitrary default, not a documented figure
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_TIME_NS = 5000;
    localparam int PROG_CYCLES_DEF =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Read source codes
    localparam logic [1:0] SRC_ROM = 2'h0;
    localparam logic [1:0] SRC_NVM = 2'h1;
    localparam logic [1:0] SRC_HOLD = 2'h2;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpe_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BYTE = 3'h2,
        ST_ROW = 3'h4
    } dpe_state_t;
endpackage

// ===== verilog/dpe_nvm_cells.sv
// Nonvolatile cell array with byte and masked row commit
`timescale 1ns/1ps
module dpe_nvm_cells
    import dpe_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic [6:0] rd_addr, // read address
    input wire logic byte_we, // commit one byte
    input wire logic [6:0] byte_addr, // byte commit address
    input wire logic [7:0] byte_data, // byte commit data
    input wire logic row_we, // commit latched row
    input wire logic [3:0] row_addr, // row number
    input wire logic [63:0] row_data, // row latch contents
    input wire logic [7:0] row_mask, // bytes loaded in row
    output logic [7:0] rdata_ff // registered read data
);
    // No reset: contents are nonvolatile
    logic [7:0] mem [NVM_BYTES];

    always_ff @(posedge clock) begin
        if (byte_we) begin
            mem[byte_addr] <= byte_data;
        end
        // Only loaded bytes are touched
        for (int i = 0; i < ROW_BYTES; i++) begin
            if (row_we && row_mask[i]) begin
                mem[{row_addr, 3'(i)}] <= row_data[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clock) begin
        rdata_ff <= mem[rd_addr];
    end
endmodule

// ===== verilog/dpe_ctrl.sv
// Data-space ROM window, bank paging and nonvolatile programming control
//
// How it works
// RULE_01 - Reads at 40h..7Fh return program ROM bytes through a window.
// RULE_02 - ROM address is window page bits above six low address bits.
// RULE_03 - Window page register at C9h, write-only, moves in 64-byte steps.
// RULE_04 - Reset leaves window page untouched; software writes it first.
// RULE_05 - Only window page bits 5..0 matter; bits 7..6 do nothing.
// RULE_06 - Software keeps RAM images of write-only registers in interrupts.
// RULE_07 - Bank select at E8h, write-only, maps a bank into 00h..3Fh.
// RULE_08 - Bank codes: 01h page 0, 02h page 1, 10h RAM page 2.
// RULE_09 - Software sets at most one bank-select bit.
// RULE_10 - Bank select survives reset, interrupts and calls unchanged.
// RULE_11 - Nonvolatile store is 128 bytes as two 64-byte pages.
// RULE_12 - Control at EAh; power-off makes nonvolatile accesses meaningless.
// RULE_13 - Nonvolatile writes without write enable are ignored.
// RULE_14 - Busy set while programming; accesses then aborted, cycle completes.
// RULE_15 - With power on and not busy, reads act as ordinary data reads; code returns FFh while row load is set.
// RULE_16 - Byte mode write programs that byte at its own address.
// RULE_17 - Row-load mode captures up to 8 same-row writes in latches.
// RULE_18 - Row start programs only latched bytes, then clears start and load.
// RULE_19 - Clearing row load before start ends row mode with no programming.
// RULE_20 - Software writes zero to control bits 5 and 4.
// RULE_21 - Control writes are ignored while busy; only busy reads back.
// RULE_22 - Reset clears the whole control register.
// RULE_23 - Row start accepted only if write enable and row load already set.
// RULE_24 - Setting row load clears latches; first write fixes the row.
// RULE_25 - Programming holds busy for a parameter number of cycles.
`timescale 1ns/1ps
module dpe_ctrl
    import dpe_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clock, // core clock, 40 MHz
    input wire logic rst, // synchronous reset, active high
    input wire dpe_req_t ds_req, // data-space request
    output logic [7:0] ds_rdata_ff, // read data
    output logic ds_rvalid_ff, // read data valid pulse
    output logic [11:0] rom_addr_ff, // program ROM address
    output logic rom_rd_ff, // program ROM read strobe
    input wire logic [7:0] rom_data, // ROM data, same cycle as strobe
    output logic nvm_busy_ff // programming in progress
);
    logic [7:0] win_page_ff;
    logic [7:0] bank_sel_ff;
    logic off_ff;
    logic we_ff;
    logic load_ff;
    logic start_ff;
    dpe_state_t state_ff;
    logic [15:0] cnt_ff;
    logic [6:0] pend_addr_ff;
    logic [7:0] pend_data_ff;
    logic [3:0] row_addr_ff;
    logic row_valid_ff;
    logic [7:0] row_mask_ff;
    logic [63:0] row_data_ff;
    logic [7:0] ram2_mem [RAM2_BYTES];
    logic rd_pend_ff;
    logic [1:0] rd_src_ff;
    logic nvm_ok_ff;
    logic [7:0] hold_ff;
    logic [7:0] nvm_rdata;
    logic [15:0] busy_len_ff;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic in_win;
    logic in_bank;
    logic wr_page;
    logic wr_bank;
    logic wr_ctl;
    logic ram_sel;
    logic nvm_sel;
    logic idle;
    logic [6:0] nvm_addr;
    logic nvm_wr;
    logic row_lat_wr;
    logic start_ok;
    logic prog_done;
    logic [7:0] ctl_status;

    assign in_win = ds_req.addr >= WIN_FIRST && ds_req.addr <= WIN_LAST;
    assign in_bank = ds_req.addr <= BANK_LAST;
    assign wr_page = ds_req.wr && ds_req.addr == ADDR_WIN_PAGE;
    assign wr_bank = ds_req.wr && ds_req.addr == ADDR_BANK_SEL;
    assign wr_ctl = ds_req.wr && ds_req.addr == ADDR_NVM_CTL;
    // RULE_08 bank decode
    assign ram_sel = bank_sel_ff[SEL_RAM2];
    assign nvm_sel = bank_sel_ff[SEL_NVM0] | bank_sel_ff[SEL_NVM1];
    // RULE_11 page plus offset
    assign nvm_addr = {bank_sel_ff[SEL_NVM1], ds_req.addr[5:0]};
    assign idle = state_ff == ST_IDLE;
    // RULE_13 write needs enable, power and idle array
    assign nvm_wr = ds_req.wr && in_bank && !ram_sel && nvm_sel &&
        !off_ff && idle && we_ff;
    // RULE_24 only the latched row is writable
    assign row_lat_wr = nvm_wr && load_ff &&
        (!row_valid_ff || nvm_addr[6:3] == row_addr_ff);
    // RULE_23 start needs enable and load already set
    assign start_ok = wr_ctl && idle && ds_req.wdata[CTL_START] &&
        ds_req.wdata[CTL_LOAD] && we_ff && load_ff;
    assign prog_done = !idle && cnt_ff == 16'h0000;
    always_comb begin
        ctl_status = 8'h00;
        ctl_status[CTL_BUSY] = nvm_busy_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-only paging registers, deliberately never reset
    // RULE_03 window page store
    // RULE_04 no reset term
    always_ff @(posedge clock) begin
        if (wr_page) begin
            win_page_ff <= ds_req.wdata;
        end
    end

    // RULE_07 bank select store
    // RULE_10 no reset term
    always_ff @(posedge clock) begin
        if (wr_bank) begin
            bank_sel_ff <= ds_req.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (ds_req.wr && in_bank && ram_sel) begin
            ram2_mem[ds_req.addr[5:0]] <= ds_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register and row latch bookkeeping
    // RULE_22 control cleared at reset
    always_ff @(posedge clock) begin
        if (rst) begin
            off_ff <= CTL_RESET[CTL_OFF];
            we_ff <= CTL_RESET[CTL_WE];
            load_ff <= CTL_RESET[CTL_LOAD];
            start_ff <= CTL_RESET[CTL_START];
            row_valid_ff <= 1'b0;
            row_mask_ff <= 8'h00;
            row_addr_ff <= 4'h0;
        end else if (prog_done && state_ff == ST_ROW) begin
            // RULE_18 end of row clears start and load
            load_ff <= 1'b0;
            start_ff <= 1'b0;
            row_valid_ff <= 1'b0;
            row_mask_ff <= 8'h00;
        end else if (wr_ctl && idle) begin
            // RULE_21 only reached while idle
            off_ff <= ds_req.wdata[CTL_OFF];
            we_ff <= ds_req.wdata[CTL_WE];
            load_ff <= ds_req.wdata[CTL_LOAD];
            // RULE_19 dropping load discards latches
            // RULE_24 raising load clears latches
            if (!ds_req.wdata[CTL_LOAD] || !load_ff) begin
                row_valid_ff <= 1'b0;
                row_mask_ff <= 8'h00;
            end
            if (start_ok) begin
                start_ff <= 1'b1;
            end
        end else if (row_lat_wr) begin
            // RULE_17 capture into volatile latch
            row_valid_ff <= 1'b1;
            row_addr_ff <= nvm_addr[6:3];
            row_mask_ff[ds_req.addr[2:0]] <= 1'b1;
        end
    end

    // RULE_17 per-byte latch data
    for (genvar i = 0; i < ROW_BYTES; i++) begin : g_row
        always_ff @(posedge clock) begin
            if (row_lat_wr && ds_req.addr[2:0] == 3'(i)) begin
                row_data_ff[i*8 +: 8] <= ds_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming sequencer
    // RULE_25 busy spans PROG_CYCLES cycles
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 16'h0000;
            nvm_busy_ff <= 1'b0;
            pend_addr_ff <= 7'h00;
            pend_data_ff <= 8'h00;
        end else if (idle) begin
            if (start_ok) begin
                // RULE_18 row program begins
                state_ff <= ST_ROW;
                cnt_ff <= 16'(PROG_CYCLES - 1);
                nvm_busy_ff <= 1'b1;
            end else if (nvm_wr && !load_ff) begin
                // RULE_16 byte program at its own address
                state_ff <= ST_BYTE;
                cnt_ff <= 16'(PROG_CYCLES - 1);
                nvm_busy_ff <= 1'b1;
                pend_addr_ff <= nvm_addr;
                pend_data_ff <= ds_req.wdata;
            end
        end else if (prog_done) begin
            state_ff <= ST_IDLE;
            nvm_busy_ff <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

    dpe_nvm_cells u_cells (
        .clock(clock),
        .rd_addr(nvm_addr),
        .byte_we(prog_done && state_ff == ST_BYTE),
        .byte_addr(pend_addr_ff),
        .byte_data(pend_data_ff),
        .row_we(prog_done && state_ff == ST_ROW),
        .row_addr(row_addr_ff),
        .row_data(row_data_ff),
        .row_mask(row_mask_ff),
        .rdata_ff(nvm_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path: two cycles for every source, so nonvolatile reads
    // match the timing of the others
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_pend_ff <= 1'b0;
            rd_src_ff <= SRC_HOLD;
            nvm_ok_ff <= 1'b0;
            hold_ff <= 8'h00;
            rom_rd_ff <= 1'b0;
            rom_addr_ff <= 12'h000;
        end else begin
            // RULE_01 window read goes to ROM
            rom_rd_ff <= ds_req.rd && in_win;
            if (ds_req.rd && in_win) begin
                // RULE_02 page above low six bits
                // RULE_05 page bits 7..6 dropped
                rom_addr_ff <= {win_page_ff[5:0], ds_req.addr[5:0]};
            end
            rd_pend_ff <= ds_req.rd && (in_win ||
                (in_bank && (ram_sel || nvm_sel)) ||
                ds_req.addr == ADDR_NVM_CTL);
            // RULE_12 power-off reads are meaningless
            // RULE_14 busy reads aborted
            nvm_ok_ff <= !off_ff && idle && !load_ff;
            if (in_win) begin
                rd_src_ff <= SRC_ROM;
            end else if (in_bank && !ram_sel) begin
                rd_src_ff <= SRC_NVM;
            end else begin
                rd_src_ff <= SRC_HOLD;
            end
            // RULE_21 control reads show busy only
            hold_ff <= in_bank ? ram2_mem[ds_req.addr[5:0]] : ctl_status;
        end
    end

    // RULE_15 same latency as other reads
    always_ff @(posedge clock) begin
        if (rst) begin
            ds_rvalid_ff <= 1'b0;
            ds_rdata_ff <= 8'h00;
        end else begin
            ds_rvalid_ff <= rd_pend_ff;
            case (rd_src_ff)
                SRC_ROM: ds_rdata_ff <= rom_data;
                SRC_NVM: ds_rdata_ff <= nvm_ok_ff ? nvm_rdata : READ_EMPTY;
                default: ds_rdata_ff <= hold_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    always_ff @(posedge clock) begin
        if (rst || !nvm_busy_ff) begin
            busy_len_ff <= 16'h0000;
        end else begin
            busy_len_ff <= busy_len_ff + 16'h0001;
        end
    end

    sequence s_win_rd;
        ds_req.rd && in_win;
    endsequence

    sequence s_row_done;
        prog_done && state_ff == ST_ROW;
    endsequence

    chk_window_read: assert property ( // RULE_01
        @(posedge clock) disable iff (rst)
            s_win_rd |=> rom_rd_ff ##1 ds_rvalid_ff
    ) else $error("window read did not strobe ROM");

    chk_rom_addr_form: assert property ( // RULE_02
        @(posedge clock) disable iff (rst) s_win_rd |=> rom_addr_ff ==
            {$past(win_page_ff[5:0]), $past(ds_req.addr[5:0])}
    ) else $error("ROM address not page over offset");

    chk_page_store: assert property ( // RULE_03
        @(posedge clock) disable iff (rst)
            wr_page |=> win_page_ff == $past(ds_req.wdata)
    ) else $error("window page not stored");

    chk_bank_store: assert property ( // RULE_07
        @(posedge clock) disable iff (rst)
            !wr_bank |=> bank_sel_ff == $past(bank_sel_ff)
    ) else $error("bank select changed without a write");

    chk_no_enable_ignore: assert property ( // RULE_13
        @(posedge clock) disable iff (rst)
            ds_req.wr && in_bank && !ram_sel && !we_ff && idle && !start_ok
            |=> !nvm_busy_ff
    ) else $error("write without enable started programming");

    chk_busy_length: assert property ( // RULE_25
        @(posedge clock) disable iff (rst)
            $fell(nvm_busy_ff) |-> busy_len_ff == 16'(PROG_CYCLES)
    ) else $error("busy length differs from programming time");

    chk_ctl_locked: assert property ( // RULE_21
        @(posedge clock) disable iff (rst) wr_ctl && nvm_busy_ff
            |=> we_ff == $past(we_ff) && off_ff == $past(off_ff)
    ) else $error("control changed while busy");

    chk_ctl_reset: assert property ( // RULE_22
        @(posedge clock) disable iff (rst) $fell(rst) |->
            !off_ff && !we_ff && !load_ff && !start_ff && !nvm_busy_ff
    ) else $error("control not cleared by reset");

    chk_start_gate: assert property ( // RULE_23
        @(posedge clock) disable iff (rst)
            wr_ctl && idle && ds_req.wdata[CTL_START] && !(we_ff && load_ff)
            |=> !start_ff && !nvm_busy_ff
    ) else $error("row start accepted without enable and load");

    chk_row_end: assert property ( // RULE_18
        @(posedge clock) disable iff (rst) s_row_done
            |=> !load_ff && !start_ff && !nvm_busy_ff
    ) else $error("row end did not clear load and start");

    chk_row_abandon: assert property ( // RULE_19
        @(posedge clock) disable iff (rst)
            wr_ctl && idle && !ds_req.wdata[CTL_LOAD]
            |=> row_mask_ff == 8'h00 && !nvm_busy_ff
    ) else $error("dropping row load kept latches");

    chk_read_timing: assert property ( // RULE_15
        @(posedge clock) disable iff (rst)
            ds_req.rd && in_bank && nvm_sel |-> ##2 ds_rvalid_ff
    ) else $error("nonvolatile read not answered in two cycles");
endmodule

// ===== verif/dpe_rom_model.sv
// Program ROM model answering window reads from the paging block
`timescale 1ns/1ps
module dpe_rom_model (
    input wire logic clock, // core clock
    input wire logic [11:0] rom_addr_ff, // ROM address from block
    input wire logic rom_rd_ff, // ROM read strobe
    output logic [7:0] rom_data // ROM data
);
    logic [7:0] last_ff;

    function automatic logic [7:0] rom_byte(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h6};
    endfunction

    always_ff @(posedge clock) begin
        if (rom_rd_ff) begin
            last_ff <= rom_byte(rom_addr_ff);
        end
    end

    // Off strobe the bus shows the inverse, so stale data never matches
    assign rom_data = rom_rd_ff ? rom_byte(rom_addr_ff) : ~last_ff;
endmodule

// ===== verif/data_space_paging_eeprom_ctrl_test.sv
// Self-checking bench for the paging and nonvolatile control block
`timescale 1ns/1ps
module data_space_paging_eeprom_ctrl_test;
    import dpe_pkg::*;
    localparam int PC = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    dpe_req_t ds_req = '0;
    logic [7:0] ds_rdata_ff, rom_data;
    logic ds_rvalid_ff, rom_rd_ff, nvm_busy_ff;
    logic [11:0] rom_addr_ff;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;

    dpe_ctrl #(.PROG_CYCLES(PC)) dpe_ctrl_i (
        .clock(clock), .rst(rst), .ds_req(ds_req),
        .ds_rdata_ff(ds_rdata_ff), .ds_rvalid_ff(ds_rvalid_ff),
        .rom_addr_ff(rom_addr_ff), .rom_rd_ff(rom_rd_ff),
        .rom_data(rom_data), .nvm_busy_ff(nvm_busy_ff));
    dpe_rom_model dpe_rom_model_i (
        .clock(clock), .rom_addr_ff(rom_addr_ff),
        .rom_rd_ff(rom_rd_ff), .rom_data(rom_data));

    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] rom_exp(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h6};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Returns one cycle after the taking edge; busy first shows right after that edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ds_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        #1 ds_req.wr = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v, output logic [12:0] rom);
        ds_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clock);
        #1 ds_req.rd = 1'b0;
        // Strobe and answer each stand for one cycle only
        rom = {rom_rd_ff, rom_addr_ff};
        @(posedge clock);
        #1 d = ds_rdata_ff;
        v = ds_rvalid_ff;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        logic [12:0] rom;
        rd(a, d, v, rom);
        check({11'h000, v}, 12'h001);
        check({4'h0, d}, {4'h0, exp});
    endtask

    task automatic rd_none(input logic [7:0] a);
        logic [7:0] d;
        logic v;
        logic [12:0] rom;
        rd(a, d, v, rom);
        check({11'h000, v}, 12'h000);
    endtask

    task automatic prog_wait(input int exp);
        int n;
        n = 0;
        while (nvm_busy_ff === 1'b1 && n < 40) begin
            n++;
            @(posedge clock);
            #1;
        end
        check(n[11:0], exp[11:0]);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_window();
        logic [7:0] pages [2];
        logic [7:0] offs [2];
        logic [7:0] d;
        logic v;
        logic [12:0] rom;
        logic [11:0] ea;
        pages = '{8'hC5, 8'h3F};
        offs = '{8'h40, 8'h7F};
        foreach (pages[i]) begin
            wr(ADDR_WIN_PAGE, pages[i]);
            foreach (offs[j]) begin
                ea = {pages[i][5:0], offs[j][5:0]};
                rd(offs[j], d, v, rom);
                check({11'h000, rom[12]}, 12'h001);
                check(rom[11:0], ea);
                check({11'h000, v}, 12'h001);
                check({4'h0, d}, {4'h0, rom_exp(ea)});
            end
        end
        rd_none(ADDR_WIN_PAGE);
        rd_none(ADDR_BANK_SEL);
    endtask

    task automatic t_byte();
        // one bank bit at a time
        wr(ADDR_BANK_SEL, BANK_NVM0);
        wr(ADDR_NVM_CTL, 8'h01);
        wr(8'h12, 8'h5A);
        check({11'h000, nvm_busy_ff}, 12'h001);
        prog_wait(PC - 1);
        wr(8'h13, 8'h3C);
        rd_chk(8'h13, READ_EMPTY);
        wr(ADDR_NVM_CTL, 8'h00);
        wr(8'h14, 8'h96);
        check({11'h000, nvm_busy_ff}, 12'h001);
        rd_chk(ADDR_NVM_CTL, 8'h02);
        prog_wait(PC - 3);
        rd_chk(8'h12, 8'h5A);
        rd_chk(8'h13, 8'h3C);
        rd_chk(8'h14, 8'h96);
    endtask

    task automatic t_refuse();
        wr(ADDR_NVM_CTL, 8'h00);
        wr(8'h12, 8'h00);
        check({11'h000, nvm_busy_ff}, 12'h000);
        rd_chk(8'h12, 8'h5A);
        wr(ADDR_NVM_CTL, 8'h41);
        wr(8'h12, 8'h00);
        check({11'h000, nvm_busy_ff}, 12'h000);
        rd_chk(8'h12, READ_EMPTY);
        wr(ADDR_NVM_CTL, 8'h01);
        rd_chk(8'h12, 8'h5A);
    endtask

    task automatic t_pages();
        wr(ADDR_BANK_SEL, BANK_NVM1);
        wr(8'h12, 8'hC3);
        prog_wait(PC - 1);
        rd_chk(8'h12, 8'hC3);
        wr(ADDR_BANK_SEL, BANK_RAM2);
        wr(8'h05, 8'h3C);
        check({11'h000, nvm_busy_ff}, 12'h000);
        rd_chk(8'h05, 8'h3C);
        wr(ADDR_BANK_SEL, BANK_NONE);
        rd_none(8'h05);
        wr(ADDR_BANK_SEL, BANK_NVM0);
        rst = 1'b1;
        @(posedge clock);
        #1 rst = 1'b0;
        @(posedge clock);
        #1;
        rd_chk(ADDR_NVM_CTL, CTL_RESET);
        rd_chk(8'h12, 8'h5A);
    endtask

    task automatic t_row();
        wr(ADDR_NVM_CTL, 8'h01);
        wr(8'h19, 8'h11);
        prog_wait(PC - 1);
        wr(ADDR_NVM_CTL, 8'h05);
        wr(8'h18, 8'hA1);
        wr(8'h1A, 8'hA2);
        wr(8'h1B, 8'hA3);
        check({11'h000, nvm_busy_ff}, 12'h000);
        wr(ADDR_NVM_CTL, 8'h0D);
        check({11'h000, nvm_busy_ff}, 12'h001);
        prog_wait(PC - 1);
        rd_chk(8'h18, 8'hA1);
        rd_chk(8'h19, 8'h11);
        rd_chk(8'h1A, 8'hA2);
        rd_chk(8'h1B, 8'hA3);
        wr(8'h1C, 8'h44);
        check({11'h000, nvm_busy_ff}, 12'h001);
        prog_wait(PC - 1);
        rd_chk(8'h1C, 8'h44);
    endtask

    task automatic t_row_abort();
        wr(ADDR_NVM_CTL, 8'h05);
        wr(8'h18, 8'h00);
        wr(ADDR_NVM_CTL, 8'h01);
        wr(ADDR_NVM_CTL, 8'h09);
        check({11'h000, nvm_busy_ff}, 12'h000);
        wr(ADDR_NVM_CTL, 8'h0D);
        check({11'h000, nvm_busy_ff}, 12'h000);
        wr(ADDR_NVM_CTL, 8'h01);
        rd_chk(8'h18, 8'hA1);
        wr(ADDR_NVM_CTL, 8'h05);
        wr(8'h1D, 8'h55);
        wr(8'h12, 8'hEE);
        wr(ADDR_NVM_CTL, 8'h0D);
        prog_wait(PC - 1);
        rd_chk(8'h1D, 8'h55);
        rd_chk(8'h18, 8'hA1);
        rd_chk(8'h12, 8'h5A);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock);
        #1;
        // Bank select has no reset term; load it before checks run
        wr(ADDR_BANK_SEL, BANK_NONE);
        rst = 1'b0;
        @(posedge clock);
        #1;
        rd_chk(ADDR_NVM_CTL, CTL_RESET);
        t_window();
        t_byte();
        t_refuse();
        t_pages();
        t_row();
        t_row_abort();
        print_verdict();
    end
endmodule
